// *** dv/autotrim_props.sv ***
`timescale 1ns/1ps
`include "autotrim_map.svh"
module autotrim_props
  import autotrim_pkg::*;
#(
  parameter int TRIM_W = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sync_pin,
  input wire axil_req_t axil_req,
  input wire axil_rsp_t axil_rsp,
  input wire logic [TRIM_W-1:0] trim_value,
  input wire logic irq
);
  logic last_pin;
  logic [3:0] since_rise;
  logic [3:0] since_wr;
  wire aw_take = axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
  wire ar_take = axil_req.arvalid && axil_rsp.arready;
  wire aw_map = axil_req.awaddr[1:0] == 2'h0 && axil_req.awaddr <= `MASK_OFFSET;
  wire ar_map = axil_req.araddr[1:0] == 2'h0 && axil_req.araddr <= `MASK_OFFSET;

  // Ages of the last pin rise and the last write, saturating at fifteen.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_pin <= 1'b0;
      since_rise <= 4'hF;
      since_wr <= 4'hF;
    end else begin
      last_pin <= sync_pin;
      since_rise <= (sync_pin && !last_pin) ? 4'h0 : since_rise + {3'h0, since_rise != 4'hF};
      since_wr <= aw_take ? 4'h0 : since_wr + {3'h0, since_wr != 4'hF};
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (aw_take |-> ##2 axil_rsp.bvalid)
    else $error("write response missing");
  a_read_answer: assert property (ar_take |=> axil_rsp.rvalid)
    else $error("read response missing");
  a_aw_drop: assert property (aw_take |=> !axil_rsp.awready)
    else $error("awready stayed high");
  a_bresp_code: assert property (aw_take && !aw_map |-> ##2 axil_rsp.bresp == `RESP_SLVERR)
    else $error("unmapped write not refused");
  a_rresp_code: assert property (ar_take |=>
    axil_rsp.rresp == ($past(ar_map) ? `RESP_OKAY : `RESP_SLVERR))
    else $error("read response code wrong");
  a_rdata_zero: assert property (ar_take && !ar_map |=> axil_rsp.rdata == 32'h0)
    else $error("unmapped read data not zero");
  a_bvalid_hold: assert property (axil_rsp.bvalid && !axil_req.bready |=>
    axil_rsp.bvalid && $stable(axil_rsp.bresp))
    else $error("write response dropped");
  a_rvalid_hold: assert property (axil_rsp.rvalid && !axil_req.rready |=>
    axil_rsp.rvalid && $stable(axil_rsp.rdata))
    else $error("read response dropped");
  a_ready_back: assert property (axil_rsp.bvalid && axil_req.bready |=>
    !axil_rsp.bvalid ##[1:2] axil_rsp.awready && axil_rsp.wready)
    else $error("write channel not reopened");
  a_trim_cause: assert property ($changed(trim_value) |->
    since_rise < 4'h8 || since_wr < 4'h4)
    else $error("trim changed without pulse or write");

  c_irq: cover property ($rose(irq));
  c_refused: cover property (axil_rsp.bvalid && axil_rsp.bresp == `RESP_SLVERR);
  c_trim: cover property ($changed(trim_value));
endmodule : autotrim_props

bind autotrim_top autotrim_props #(.TRIM_W(TRIM_W)) autotrim_props_inst (
  .aclk(aclk),
  .aresetn(aresetn),
  .sync_pin(sync_pin),
  .axil_req(axil_req),
  .axil_rsp(axil_rsp),
  .trim_value(trim_value),
  .irq(irq)
);

// *** dv/oscillator_frequency_error_autotrim_tb_top.sv ***
`timescale 1ns/1ps
`include "autotrim_map.svh"
module oscillator_frequency_error_autotrim_tb_top
  import autotrim_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic fire = 1'b0;
  logic sync_pin;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  logic [5:0] trim;
  logic irq;
  logic [31:0] q;
  int cyc = 0;
  int tf = 0;
  int n_errors = 0;
  int checked = 0;

  always #50 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  autotrim_top #(.TRIM_W(6)) autotrim_top_inst (.aclk(aclk), .aresetn(aresetn),
    .sync_pin(sync_pin), .axil_req(req), .axil_rsp(rsp), .trim_value(trim), .irq(irq));
  sync_source sync_source_inst (.aclk(aclk), .fire(fire), .sync_pin(sync_pin));

  task close_out;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  task cmp_rng(input string nm, input int lo, input int hi, input logic [15:0] s);
    checked++;
    if ($isunknown(s) || s < lo || s > hi) begin
      n_errors++;
      $display("unexpected %s: expected %0d to %0d seen %h", nm, lo, hi, s);
    end
  endtask : cmp_rng

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge aclk);
    req.awvalid <= wr;
    req.wvalid <= wr;
    req.arvalid <= !wr;
    req.awaddr <= a;
    req.araddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (wr ? rsp.bvalid && req.bready : rsp.rvalid && req.rready) begin
        q = rsp.rdata;
        cmp("response", er, wr ? rsp.bresp : rsp.rresp);
        req.bready <= 1'b0;
        req.rready <= 1'b0;
        return;
      end
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.arready) req.arvalid <= 1'b0;
      // The response ready rises only once the request has been taken.
      if (!(req.awvalid || req.wvalid || req.arvalid)) begin
        req.bready <= wr;
        req.rready <= !wr;
      end
    end
    n_errors++;
    $display("unexpected bus answer: expected response seen none");
    close_out;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, `RESP_OKAY);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    bus(1'b0, a, 32'h0, er);
    cmp("read data", e, q);
  endtask : rd

  task at(input int t);
    while (cyc < t) @(posedge aclk);
  endtask : at

  task pulse(input int p);
    at(tf + p);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    tf = tf + p;
  endtask : pulse

  // Reload is 99, so an on-time pulse comes 100 cycles after the last one.
  task meas(input int p, input logic [5:0] f, input logic [5:0] m, input logic [5:0] tr,
            input bit clr);
    int e;
    pulse(p);
    e = p > 100 ? p - 100 : 100 - p;
    if (e > 256) e = 256;
    repeat (6) @(posedge aclk);
    bus(1'b0, `STATUS_OFFSET, 32'h0, `RESP_OKAY);
    cmp("flags", f & m, q[5:0] & m);
    if (p != 100) cmp("direction", p < 100, q[`STATUS_DIR_BIT]);
    cmp_rng("capture", e > 2 ? e - 2 : 0, e + 2, q[31:16]);
    cmp("trim", tr, trim);
    cmp("irq", f[0], irq);
    if (clr) begin
      wr(`STATUS_OFFSET, 32'h3F);
      repeat (2) @(posedge aclk);
      cmp("irq after clear", 32'h0, irq);
    end
    $display("test with period %0d done", p);
  endtask : meas

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CTRL_OFFSET, 32'h00002000, `RESP_OKAY);
    rd(`CFG_OFFSET, {16'h0022, 16'(48000000 / 1000 - 1)}, `RESP_OKAY);
    rd(`STATUS_OFFSET, 32'h0, `RESP_OKAY);
    rd(`MASK_OFFSET, 32'h0, `RESP_OKAY);
    rd(8'h10, 32'h0, `RESP_SLVERR);
    rd(8'h02, 32'h0, `RESP_SLVERR);
    bus(1'b1, 8'h10, 32'hFFFFFFFF, `RESP_SLVERR);
    $display("register test done");
    wr(`CFG_OFFSET, 32'h00020063);
    rd(`CFG_OFFSET, 32'h00020063, `RESP_OKAY);
    wr(`MASK_OFFSET, 32'h1);
    wr(`CTRL_OFFSET, 32'h00002003);
    tf = cyc;
    pulse(0);
    meas(100, 6'h01, 6'h3B, 6'h20, 1'b1);
    meas(104, 6'h01, 6'h3B, 6'h1F, 1'b1);
    meas(96, 6'h01, 6'h3B, 6'h20, 1'b0);
    meas(90, 6'h03, 6'h3B, 6'h22, 1'b1);
    wr(`CTRL_OFFSET, 32'h00000503);
    rd(`CTRL_OFFSET, 32'h00002203, `RESP_OKAY);
    at(tf + 300);
    bus(1'b0, `STATUS_OFFSET, 32'h0, `RESP_OKAY);
    cmp("early flags", 32'h04, q & 32'h14);
    meas(400, 6'h1C, 6'h3F, 6'h22, 1'b1);
    // Trim writes count only once automatic mode is already off.
    wr(`CTRL_OFFSET, 32'h00000002);
    wr(`CTRL_OFFSET, 32'h00001002);
    meas(90, 6'h02, 6'h3B, 6'h10, 1'b1);
    wr(`CTRL_OFFSET, 32'h00003F02);
    wr(`CTRL_OFFSET, 32'h00003F03);
    meas(90, 6'h22, 6'h3B, 6'h3F, 1'b1);
    wr(`CTRL_OFFSET, 32'h00000002);
    wr(`CTRL_OFFSET, 32'h00000003);
    meas(110, 6'h22, 6'h3B, 6'h00, 1'b1);
    close_out;
  end
endmodule : oscillator_frequency_error_autotrim_tb_top

// *** dv/sync_source.sv ***
`timescale 1ns/1ps
module sync_source #(
  parameter int HIGH_CYC = 4,
  parameter int LAG = 0
) (
  input wire logic aclk,
  input wire logic fire,
  output logic sync_pin
);
  int left = 0;

  // Each request gives one rising edge LAG cycles later, high for HIGH_CYC cycles.
  always @(posedge aclk) begin
    if (fire) begin
      left <= HIGH_CYC + LAG;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end

  // The pin rests low between pulses.
  assign sync_pin = left > 0 && left <= HIGH_CYC;
endmodule : sync_source

// *** verilog/autotrim_map.svh ***
`ifndef AUTOTRIM_MAP_SVH
`define AUTOTRIM_MAP_SVH

// Register byte offsets.
`define CTRL_OFFSET 8'h00
`define CFG_OFFSET 8'h04
`define STATUS_OFFSET 8'h08
`define MASK_OFFSET 8'h0C

// Control register fields.
`define CTRL_AUTO_BIT 0
`define CTRL_COUNT_EN_BIT 1
`define CTRL_TRIM_LSB 8

// Configuration register fields.
`define CFG_RELOAD_LSB 0
`define CFG_LIMIT_LSB 16

// Status register fields; flag bits share their positions with the mask register.
`define FLAG_OK_BIT 0
`define FLAG_WARN_BIT 1
`define FLAG_EXPECT_BIT 2
`define FLAG_ERROR_BIT 3
`define FLAG_MISS_BIT 4
`define FLAG_OVF_BIT 5
`define STATUS_DIR_BIT 15
`define STATUS_CAP_LSB 16

// Reload reset value follows from the target and reference rates.
`define TARGET_FREQ_HZ 48000000
`define SYNC_FREQ_HZ 1000
`define RELOAD_RESET 16'hBB7F

// Other reset values.
`define LIMIT_RESET 8'h22
`define TRIM_RESET 6'h20

// Evaluation scale factors.
`define WARN_SCALE 3
`define OUT_SHIFT 7

// AXI4-Lite responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** verilog/autotrim_pkg.sv ***
package autotrim_pkg;

  typedef enum logic [3:0] {
    CNT_IDLE = 4'b0001,
    CNT_DOWN = 4'b0010,
    CNT_UP = 4'b0100,
    CNT_STOP = 4'b1000
  } count_state_t;

  typedef struct packed {
    logic adjust_overflow_flag;
    logic missed_pulse_flag;
    logic pulse_error_flag;
    logic expected_pulse_event;
    logic pulse_warning_flag;
    logic pulse_ok_flag;
  } flags_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

endpackage : autotrim_pkg

// *** verilog/autotrim_top.sv ***
// Behaviour
// - 16-bit down/up counter reloaded per pulse.
// - Down to zero raises expected-pulse event.
// - Up to error limit, stop, flag miss.
// - Error limit is limit field times 128.
// - Pulse captures count value and direction.
// - Down means slow, raise trim; up lowers.
// - Tolerance limit is the field unscaled.
// - Warning limit is three times field.
// - Trimming only while auto-adjust enabled.
// - Below tolerance: ok, trim unchanged.
// - Below warning: ok, one trim step.
// - Below error limit: warning, two steps.
// - At error limit: error, trim unchanged.
// - Trim saturates at limits, flags overflow.
// - Auto mode makes trim read-only.
// - Reload resets for 48 MHz over 1 kHz.
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "autotrim_map.svh"

module autotrim_top
  import autotrim_pkg::*;
#(
  parameter int TRIM_W = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sync_pin,
  input wire axil_req_t axil_req,
  output axil_rsp_t axil_rsp,
  output logic [TRIM_W-1:0] trim_value,
  output logic irq
);

  // ******************************************************************
  // Functions
  // ******************************************************************

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : strb_mask

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = strb_mask(strb);
    return (old_v & ~m) | (new_v & m);
  endfunction : merge

  // Returns {overflow, trim} after moving the trim by step in the given direction.
  function automatic logic [TRIM_W:0] adjust(input logic [TRIM_W-1:0] trim,
                                             input logic raise, input logic [1:0] step);
    logic [TRIM_W+1:0] wide;
    logic [TRIM_W+1:0] top;
    top = {2'b00, {TRIM_W{1'b1}}};
    if (raise) begin
      wide = {2'b00, trim} + {{TRIM_W{1'b0}}, step};
      if (wide > top) begin
        return {1'b1, {TRIM_W{1'b1}}};
      end
    end else begin
      wide = {2'b00, trim} - {{TRIM_W{1'b0}}, step};
      if ({2'b00, trim} < {{TRIM_W{1'b0}}, step}) begin
        return {1'b1, {TRIM_W{1'b0}}};
      end
    end
    return {1'b0, wide[TRIM_W-1:0]};
  endfunction : adjust

  // ******************************************************************
  // Registers and state
  // ******************************************************************

  logic auto_adjust_enable;
  logic count_enable;
  logic [15:0] reload;
  logic [7:0] error_limit_field;
  flags_t flags;
  flags_t mask;
  logic error_direction_bit;
  logic [15:0] error_capture_field;

  count_state_t state;
  logic [15:0] count;

  logic sync_event;
  logic [7:0] aw_addr;
  logic aw_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_full;
  logic do_write;

  flags_t flag_set;
  flags_t flag_clr;
  logic trim_hw_we;
  logic [TRIM_W-1:0] trim_hw_value;

  // ******************************************************************
  // Reference pulse input
  // ******************************************************************

  sync_pulse_detect sync_in (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(sync_pin),
    .pulse(sync_event)
  );

  // ******************************************************************
  // Limits
  // ******************************************************************

  logic [16:0] tol_limit;
  logic [16:0] warn_limit;
  logic [16:0] error_limit;
  logic [16:0] error_mag;

  assign tol_limit = {9'h000, error_limit_field};
  assign warn_limit = 17'(`WARN_SCALE * error_limit_field);
  assign error_limit = 17'({9'h000, error_limit_field} << `OUT_SHIFT);
  assign error_mag = {1'b0, count};

  logic measure;
  logic counting_down;
  assign measure = sync_event && count_enable && (state != CNT_IDLE);
  assign counting_down = (state == CNT_DOWN);

  // ******************************************************************
  // Error counter
  // ******************************************************************

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= CNT_IDLE;
      count <= 16'h0000;
    end else if (!count_enable) begin
      state <= CNT_IDLE;
      count <= 16'h0000;
    end else if (sync_event) begin
      state <= CNT_DOWN;
      count <= reload;
    end else begin
      case (state)
        CNT_IDLE: begin
          state <= CNT_IDLE;
        end
        CNT_DOWN: begin
          if (count == 16'h0000) begin
            state <= CNT_UP;
          end else begin
            count <= count - 16'h0001;
          end
        end
        CNT_UP: begin
          if (error_mag >= error_limit) begin
            state <= CNT_STOP;
          end else begin
            count <= count + 16'h0001;
          end
        end
        CNT_STOP: begin
          state <= CNT_STOP;
        end
        default: begin
          state <= CNT_IDLE;
        end
      endcase
    end
  end

  // ******************************************************************
  // Capture
  // ******************************************************************

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_capture_field <= 16'h0000;
      error_direction_bit <= 1'b0;
    end else if (measure) begin
      error_capture_field <= count;
      error_direction_bit <= counting_down;
    end
  end

  // ******************************************************************
  // Evaluation and automatic trimming
  // ******************************************************************

  always_comb begin
    logic [TRIM_W:0] adj;
    adj = {1'b0, trim_value};
    flag_set = '0;
    trim_hw_we = 1'b0;
    trim_hw_value = trim_value;
    if (count_enable && !sync_event) begin
      if (state == CNT_DOWN && count == 16'h0000) begin
        flag_set.expected_pulse_event = 1'b1;
      end
      if (state == CNT_UP && error_mag >= error_limit) begin
        flag_set.missed_pulse_flag = 1'b1;
      end
    end
    if (measure) begin
      if (error_mag < tol_limit) begin
        flag_set.pulse_ok_flag = 1'b1;
      end else if (error_mag < warn_limit) begin
        flag_set.pulse_ok_flag = 1'b1;
        adj = adjust(trim_value, counting_down, 2'h1);
        trim_hw_we = 1'b1;
      end else if (error_mag < error_limit) begin
        flag_set.pulse_warning_flag = 1'b1;
        adj = adjust(trim_value, counting_down, 2'h2);
        trim_hw_we = 1'b1;
      end else begin
        flag_set.pulse_error_flag = 1'b1;
      end
      if (!auto_adjust_enable) begin
        trim_hw_we = 1'b0;
      end
      if (trim_hw_we) begin
        trim_hw_value = adj[TRIM_W-1:0];
        flag_set.adjust_overflow_flag = adj[TRIM_W];
      end
    end
  end

  // ******************************************************************
  // Write channels
  // ******************************************************************

  assign do_write = aw_full && w_full && !axil_rsp.bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      axil_rsp.awready <= 1'b0;
    end else if (axil_req.awvalid && axil_rsp.awready) begin
      aw_full <= 1'b1;
      aw_addr <= axil_req.awaddr;
      axil_rsp.awready <= 1'b0;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end else if (!aw_full && !axil_rsp.bvalid) begin
      axil_rsp.awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      axil_rsp.wready <= 1'b0;
    end else if (axil_req.wvalid && axil_rsp.wready) begin
      w_full <= 1'b1;
      w_data <= axil_req.wdata;
      w_strb <= axil_req.wstrb;
      axil_rsp.wready <= 1'b0;
    end else if (do_write) begin
      w_full <= 1'b0;
    end else if (!w_full && !axil_rsp.bvalid) begin
      axil_rsp.wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axil_rsp.bvalid <= 1'b0;
      axil_rsp.bresp <= `RESP_OKAY;
    end else if (do_write) begin
      axil_rsp.bvalid <= 1'b1;
      if (aw_addr <= `MASK_OFFSET && aw_addr[1:0] == 2'b00) begin
        axil_rsp.bresp <= `RESP_OKAY;
      end else begin
        axil_rsp.bresp <= `RESP_SLVERR;
      end
    end else if (axil_req.bready) begin
      axil_rsp.bvalid <= 1'b0;
    end
  end

  // ******************************************************************
  // Register updates
  // ******************************************************************

  logic [31:0] ctrl_word;
  logic [31:0] cfg_word;
  logic [31:0] ctrl_new;
  logic [31:0] cfg_new;
  logic [31:0] status_word;

  assign ctrl_word = {16'h0000, 2'b00, TRIM_W'(0) | 6'(trim_value), 6'h00,
                      count_enable, auto_adjust_enable};
  assign cfg_word = {8'h00, error_limit_field, reload};
  assign ctrl_new = merge(ctrl_word, w_data, w_strb);
  assign cfg_new = merge(cfg_word, w_data, w_strb);
  assign status_word = {error_capture_field, error_direction_bit, 9'h000, flags};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_adjust_enable <= 1'b0;
      count_enable <= 1'b0;
      trim_value <= `TRIM_RESET;
    end else begin
      if (do_write && aw_addr == `CTRL_OFFSET) begin
        auto_adjust_enable <= ctrl_new[`CTRL_AUTO_BIT];
        count_enable <= ctrl_new[`CTRL_COUNT_EN_BIT];
      end
      if (trim_hw_we) begin
        trim_value <= trim_hw_value;
      end else if (do_write && aw_addr == `CTRL_OFFSET && !auto_adjust_enable) begin
        trim_value <= ctrl_new[`CTRL_TRIM_LSB +: TRIM_W];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload <= `RELOAD_RESET;
      error_limit_field <= `LIMIT_RESET;
    end else if (do_write && aw_addr == `CFG_OFFSET) begin
      reload <= cfg_new[`CFG_RELOAD_LSB +: 16];
      error_limit_field <= cfg_new[`CFG_LIMIT_LSB +: 8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= '0;
    end else if (do_write && aw_addr == `MASK_OFFSET) begin
      mask <= flags_t'(6'(merge({26'h0, mask}, w_data, w_strb)));
    end
  end

  // ******************************************************************
  // Flags and interrupt
  // ******************************************************************

  always_comb begin
    flag_clr = '0;
    if (do_write && aw_addr == `STATUS_OFFSET) begin
      flag_clr = flags_t'(w_data[5:0] & {6{w_strb[0]}});
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & mask);
    end
  end

  // ******************************************************************
  // Read channel
  // ******************************************************************

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axil_rsp.arready <= 1'b0;
      axil_rsp.rvalid <= 1'b0;
      axil_rsp.rdata <= 32'h0000_0000;
      axil_rsp.rresp <= `RESP_OKAY;
    end else if (axil_req.arvalid && axil_rsp.arready) begin
      axil_rsp.arready <= 1'b0;
      axil_rsp.rvalid <= 1'b1;
      axil_rsp.rresp <= `RESP_OKAY;
      case (axil_req.araddr)
        `CTRL_OFFSET: axil_rsp.rdata <= ctrl_word;
        `CFG_OFFSET: axil_rsp.rdata <= cfg_word;
        `STATUS_OFFSET: axil_rsp.rdata <= status_word;
        `MASK_OFFSET: axil_rsp.rdata <= {26'h0, mask};
        default: begin
          axil_rsp.rdata <= 32'h0000_0000;
          axil_rsp.rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (axil_rsp.rvalid) begin
      if (axil_req.rready) begin
        axil_rsp.rvalid <= 1'b0;
      end
    end else begin
      axil_rsp.arready <= 1'b1;
    end
  end

endmodule : autotrim_top

// *** verilog/sync_pulse_detect.sv ***
`timescale 1ns/1ps

module sync_pulse_detect (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic pulse
);

  logic meta;
  logic stable;
  logic stable_d;

  // Two-stage synchroniser; only the second stage feeds the edge detector.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b0;
      stable <= 1'b0;
      stable_d <= 1'b0;
    end else begin
      meta <= pin;
      stable <= meta;
      stable_d <= stable;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse <= 1'b0;
    end else begin
      pulse <= stable & ~stable_d;
    end
  end

endmodule : sync_pulse_detect
